// File: rtl/dcc_arr_if.sv
// Purpose: Lookup, write and invalidate port between controller and line store.
// Assumes: Reads are combinational on rd_idx.
// Notes:   Invalidate wins over a write to the same line in one clock.
`timescale 1ns/1ps
`default_nettype none

interface dcc_arr_if;
  import dcc_pkg::*;
  logic [DCC_IDX_W-1:0] rd_idx;
  logic [DCC_TAG_W-1:0] rd_tag;
  logic rd_lvalid;
  logic [DCC_WORDS-1:0] rd_wvalid;
  logic [DCC_LINE_W-1:0] rd_data;
  logic wr_en;
  logic [DCC_IDX_W-1:0] wr_idx;
  logic [DCC_TAG_W-1:0] wr_tag;
  logic [DCC_WORDS-1:0] wr_mask;
  logic [DCC_LINE_W-1:0] wr_data;
  logic inv_en;
  logic [DCC_IDX_W-1:0] inv_idx;

  modport ctrl (output rd_idx, wr_en, wr_idx, wr_tag, wr_mask, wr_data, inv_en, inv_idx,
                input rd_tag, rd_lvalid, rd_wvalid, rd_data);
  modport arr (input rd_idx, wr_en, wr_idx, wr_tag, wr_mask, wr_data, inv_en, inv_idx,
               output rd_tag, rd_lvalid, rd_wvalid, rd_data);
endinterface : dcc_arr_if

`default_nettype wire

// File: rtl/dcc_ctrl.sv
// Purpose: Data cache coherency and issue controller between core and bus control unit.
// Assumes: The bus control unit answers loads in request order, one word per beat.
// Notes:   A request is taken when its valid meets the matching registered ready.
`timescale 1ns/1ps
`default_nettype none

module dcc_ctrl
  import dcc_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // Global control
  input wire logic i_cache_enable,
  input wire logic i_dma_active,
  // User process issue
  input wire logic i_usr_valid,
  input wire logic i_usr_store,
  input wire logic i_usr_atomic,
  input wire logic i_usr_cacheable,
  input wire logic [DCC_ADDR_W-1:0] i_usr_addr,
  input wire logic [1:0] i_usr_nwords,
  input wire logic [DCC_LINE_W-1:0] i_usr_wdata,
  output logic o_usr_ld_rdy,
  output logic o_usr_st_rdy,
  // DMA process issue
  input wire logic i_dma_valid,
  input wire logic i_dma_store,
  input wire logic [DCC_ADDR_W-1:0] i_dma_addr,
  input wire logic [1:0] i_dma_nwords,
  input wire logic [DCC_LINE_W-1:0] i_dma_wdata,
  output logic o_dma_ld_rdy,
  output logic o_dma_st_rdy,
  // Load return bus
  output logic o_ld_valid,
  output logic o_ld_src,
  output logic [DCC_LINE_W-1:0] o_ld_data,
  // Bus control unit request
  output logic o_bcu_req_valid,
  output logic o_bcu_req_store,
  output logic o_bcu_req_dma,
  output logic o_bcu_req_cacheable,
  output logic [DCC_ADDR_W-1:0] o_bcu_req_addr,
  output logic [1:0] o_bcu_req_nwords,
  output logic [DCC_LINE_W-1:0] o_bcu_req_wdata,
  input wire logic i_bcu_req_ready,
  // Bus control unit load response
  input wire logic i_bcu_rsp_valid,
  input wire logic [DCC_WORD_W-1:0] i_bcu_rsp_word
);

  dcc_arr_if arr ();

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic cache_on_q, cache_on_d;
  logic ld_vld_q, ld_vld_d;
  logic ld_src_q, ld_src_d;
  logic [DCC_LINE_W-1:0] ld_data_q, ld_data_d;
  logic bv_q, bv_d, bs_q, bs_d, bd_q, bd_d, bc_q, bc_d;
  logic [DCC_ADDR_W-1:0] ba_q, ba_d;
  logic [1:0] bn_q, bn_d;
  logic [DCC_LINE_W-1:0] bw_q, bw_d;
  logic [DCC_ADDR_W-1:0] pa_q [DCC_QUEUES];
  logic [DCC_ADDR_W-1:0] pa_d [DCC_QUEUES];
  logic [1:0] pn_q [DCC_QUEUES];
  logic [1:0] pn_d [DCC_QUEUES];
  logic [DCC_QUEUES-1:0] pc_q, pc_d, ps_q, ps_d;
  logic [1:0] wp_q, wp_d, rp_q, rp_d;
  logic [1:0] usr_cnt_q, usr_cnt_d, dma_cnt_q, dma_cnt_d, cach_cnt_q, cach_cnt_d;
  logic [1:0] beat_q, beat_d;
  logic [DCC_LINE_W-1:0] asm_q, asm_d;
  logic hv_q, hv_d, hc_q, hc_d, hs_q, hs_d;
  logic [DCC_ADDR_W-1:0] ha_q, ha_d;
  logic [1:0] hn_q, hn_d;

  // Request decode
  logic usr_go, dma_go, go, req_store, req_cach, tag_hit, ld_hit, push, pop;
  logic [DCC_ADDR_W-1:0] req_addr;
  logic [1:0] req_nw, req_off;
  logic [DCC_LINE_W-1:0] req_wdata, hit_data;
  logic [DCC_WORDS-1:0] req_mask;

  // ----------------------------------------------------------------------
  // Request selection and lookup
  // ----------------------------------------------------------------------
  always_comb begin
    usr_go = i_usr_valid && (i_usr_store ? o_usr_st_rdy : o_usr_ld_rdy);
    dma_go = i_dma_valid && (i_dma_store ? o_dma_st_rdy : o_dma_ld_rdy);
    go = usr_go || dma_go;
    req_store = dma_go ? i_dma_store : i_usr_store;
    req_addr = dma_go ? i_dma_addr : i_usr_addr;
    req_nw = dma_go ? i_dma_nwords : i_usr_nwords;
    req_wdata = dma_go ? i_dma_wdata : i_usr_wdata;
    req_off = dcc_wrd_of(req_addr);
    req_mask = dcc_word_mask(req_off, req_nw);
    hit_data = arr.rd_data >> {req_off, 5'h0};
    req_cach = go && !dma_go && cache_on_q && i_usr_cacheable && !i_usr_atomic;
    tag_hit = arr.rd_lvalid && arr.rd_tag == dcc_tag_of(req_addr);
    ld_hit = go && !req_store && req_cach && tag_hit
             && (arr.rd_wvalid & req_mask) == req_mask;
    push = go && !req_store && !ld_hit;
    pop = i_bcu_rsp_valid && beat_q == pn_q[rp_q];
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    cache_on_d = i_cache_enable;
    arr.rd_idx = dcc_idx_of(req_addr);
    arr.wr_en = 1'b0;
    arr.wr_idx = dcc_idx_of(req_addr);
    arr.wr_tag = dcc_tag_of(req_addr);
    arr.wr_mask = req_mask;
    arr.wr_data = req_wdata << {req_off, 5'h0};
    arr.inv_en = go && req_store && !req_cach && tag_hit;
    arr.inv_idx = dcc_idx_of(req_addr);
    ld_vld_d = ld_hit;
    ld_src_d = dma_go;
    ld_data_d = hit_data;
    if (go && req_store && req_cach) begin
      arr.wr_en = 1'b1;
    end
    if (hv_q) begin
      // A held fill owns the store port; issue was blocked for this clock.
      arr.wr_en = hc_q;
      arr.wr_idx = dcc_idx_of(ha_q);
      arr.wr_tag = dcc_tag_of(ha_q);
      arr.wr_mask = dcc_word_mask(dcc_wrd_of(ha_q), hn_q);
      arr.wr_data = asm_q << {dcc_wrd_of(ha_q), 5'h0};
      ld_vld_d = 1'b1;
      ld_src_d = hs_q;
      ld_data_d = asm_q;
    end
    // Bus control unit request register: misses and all stores.
    bv_d = bv_q && !i_bcu_req_ready;
    bs_d = bs_q;
    bd_d = bd_q;
    bc_d = bc_q;
    ba_d = ba_q;
    bn_d = bn_q;
    bw_d = bw_q;
    if (push || (go && req_store)) begin
      bv_d = 1'b1;
      bs_d = req_store;
      bd_d = dma_go;
      bc_d = req_cach;
      ba_d = req_addr;
      bn_d = req_nw;
      bw_d = req_wdata;
    end
    // Outstanding loads, answered in order.
    pa_d = pa_q;
    pn_d = pn_q;
    pc_d = pc_q;
    ps_d = ps_q;
    wp_d = wp_q;
    rp_d = rp_q;
    usr_cnt_d = usr_cnt_q;
    dma_cnt_d = dma_cnt_q;
    cach_cnt_d = cach_cnt_q;
    if (push) begin
      pa_d[wp_q] = req_addr;
      pn_d[wp_q] = req_nw;
      pc_d[wp_q] = req_cach;
      ps_d[wp_q] = dma_go;
      wp_d = dcc_ptr_inc(wp_q);
      if (dma_go) dma_cnt_d = dma_cnt_d + 2'h1;
      else usr_cnt_d = usr_cnt_d + 2'h1;
      if (req_cach) cach_cnt_d = cach_cnt_d + 2'h1;
    end
    beat_d = beat_q;
    asm_d = asm_q;
    hv_d = 1'b0;
    hc_d = hc_q;
    hs_d = hs_q;
    ha_d = ha_q;
    hn_d = hn_q;
    if (i_bcu_rsp_valid) begin
      asm_d[{beat_q, 5'h0} +: DCC_WORD_W] = i_bcu_rsp_word;
      beat_d = beat_q + 2'h1;
    end
    if (pop) begin
      beat_d = 2'h0;
      hv_d = 1'b1;
      hc_d = pc_q[rp_q];
      hs_d = ps_q[rp_q];
      ha_d = pa_q[rp_q];
      hn_d = pn_q[rp_q];
      rp_d = dcc_ptr_inc(rp_q);
      if (ps_q[rp_q]) dma_cnt_d = dma_cnt_d - 2'h1;
      else usr_cnt_d = usr_cnt_d - 2'h1;
      if (pc_q[rp_q]) cach_cnt_d = cach_cnt_d - 2'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      cache_on_q <= DCC_CACHE_ON_RST;
      ld_vld_q <= 1'b0;
      ld_src_q <= 1'b0;
      ld_data_q <= '0;
      bv_q <= 1'b0;
      bs_q <= 1'b0;
      bd_q <= 1'b0;
      bc_q <= 1'b0;
      ba_q <= '0;
      bn_q <= 2'h0;
      bw_q <= '0;
      pa_q <= '{default: '0};
      pn_q <= '{default: 2'h0};
      pc_q <= '0;
      ps_q <= '0;
      wp_q <= 2'h0;
      rp_q <= 2'h0;
      usr_cnt_q <= 2'h0;
      dma_cnt_q <= 2'h0;
      cach_cnt_q <= 2'h0;
      beat_q <= 2'h0;
      asm_q <= '0;
      hv_q <= 1'b0;
      hc_q <= 1'b0;
      hs_q <= 1'b0;
      ha_q <= '0;
      hn_q <= 2'h0;
    end else begin
      cache_on_q <= cache_on_d;
      ld_vld_q <= ld_vld_d;
      ld_src_q <= ld_src_d;
      ld_data_q <= ld_data_d;
      bv_q <= bv_d;
      bs_q <= bs_d;
      bd_q <= bd_d;
      bc_q <= bc_d;
      ba_q <= ba_d;
      bn_q <= bn_d;
      bw_q <= bw_d;
      pa_q <= pa_d;
      pn_q <= pn_d;
      pc_q <= pc_d;
      ps_q <= ps_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
      usr_cnt_q <= usr_cnt_d;
      dma_cnt_q <= dma_cnt_d;
      cach_cnt_q <= cach_cnt_d;
      beat_q <= beat_d;
      asm_q <= asm_d;
      hv_q <= hv_d;
      hc_q <= hc_d;
      hs_q <= hs_d;
      ha_q <= ha_d;
      hn_q <= hn_d;
    end
  end

  assign o_ld_valid = ld_vld_q;
  assign o_ld_src = ld_src_q;
  assign o_ld_data = ld_data_q;
  assign o_bcu_req_valid = bv_q;
  assign o_bcu_req_store = bs_q;
  assign o_bcu_req_dma = bd_q;
  assign o_bcu_req_cacheable = bc_q;
  assign o_bcu_req_addr = ba_q;
  assign o_bcu_req_nwords = bn_q;
  assign o_bcu_req_wdata = bw_q;

  // ----------------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------------
  dcc_tag_array u_array (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .arr(arr.arr)
  );

  // A pending request register blocks issue until it is taken; a held fill blocks it for one clock.
  dcc_issue_arb u_arb (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_dma_active(i_dma_active),
    .i_block(bv_d || hv_d),
    .i_usr_cnt(usr_cnt_d),
    .i_dma_cnt(dma_cnt_d),
    .i_cach_cnt(cach_cnt_d),
    .o_usr_ld_rdy(o_usr_ld_rdy),
    .o_usr_st_rdy(o_usr_st_rdy),
    .o_dma_ld_rdy(o_dma_ld_rdy),
    .o_dma_st_rdy(o_dma_st_rdy)
  );

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  AST_HIT_NEXT_CLOCK: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    ld_hit |=> o_ld_valid && o_ld_data == $past(hit_data))
    else $error("Load hit data not returned in the next clock.");
  AST_MISS_TO_BCU: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    push |=> o_bcu_req_valid && !o_bcu_req_store && o_bcu_req_addr == $past(req_addr))
    else $error("Missed load not handed over in the next clock.");
  AST_MISS_HOLDOFF: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    push |=> !o_usr_ld_rdy && !o_dma_ld_rdy)
    else $error("Load issue allowed in the clock after a miss.");
  AST_NONCACHE_SRC: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (dma_go || (usr_go && i_usr_atomic)) |-> !req_cach)
    else $error("DMA or atomic access treated as cacheable.");
  AST_DISABLED_SNOOP: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (go && req_store && !cache_on_q && tag_hit) |-> arr.inv_en && !arr.wr_en)
    else $error("Store with cache disabled did not invalidate a matching line.");
  AST_STORE_STALL: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (cach_cnt_q != 2'h0) |-> !usr_go || !i_usr_store)
    else $error("User store taken while a cacheable load was outstanding.");
  AST_DMA_STORE_SENT: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (dma_go && i_dma_store) |=> o_bcu_req_valid && o_bcu_req_dma && o_bcu_req_store)
    else $error("DMA store not passed to the bus control unit.");
  AST_FILL_TOGETHER: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (pop && pc_q[rp_q]) |=> arr.wr_en ##1 o_ld_valid)
    else $error("Miss fill did not update cache and return data together.");
  AST_STORE_WRITES: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (go && req_store && req_cach) |-> arr.wr_en && arr.wr_mask == req_mask)
    else $error("Cacheable store not written into the cache on issue.");

endmodule : dcc_ctrl

`default_nettype wire

// File: rtl/dcc_issue_arb.sv
// Purpose: Registered issue permissions for the user and DMA processes.
// Assumes: Counts given are next-clock values.
// Notes:   Turns alternate every clock while DMA is active.
`timescale 1ns/1ps
`default_nettype none

module dcc_issue_arb
  import dcc_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // State of the controller for the next clock
  input wire logic i_dma_active,
  input wire logic i_block,
  input wire logic [1:0] i_usr_cnt,
  input wire logic [1:0] i_dma_cnt,
  input wire logic [1:0] i_cach_cnt,
  // Permissions
  output logic o_usr_ld_rdy,
  output logic o_usr_st_rdy,
  output logic o_dma_ld_rdy,
  output logic o_dma_st_rdy
);

  dcc_src_t turn_q, turn_d;
  logic usr_ld_d, usr_st_d, dma_ld_d, dma_st_d;
  logic usr_turn, dma_turn;
  logic [1:0] usr_lim;
  logic [2:0] tot;

  always_comb begin
    turn_d = DCC_SRC_USR;
    if (i_dma_active) begin
      turn_d = (turn_q == DCC_SRC_USR) ? DCC_SRC_DMA : DCC_SRC_USR;
    end
    usr_turn = !i_dma_active || turn_d == DCC_SRC_USR;
    dma_turn = i_dma_active && turn_d == DCC_SRC_DMA;
    usr_lim = i_dma_active ? DCC_USR_Q_DMA_ON : DCC_QUEUES;
    tot = {1'b0, i_usr_cnt} + {1'b0, i_dma_cnt};
    usr_ld_d = !i_block && usr_turn && i_usr_cnt < usr_lim && tot < {1'b0, DCC_QUEUES};
    usr_st_d = !i_block && usr_turn && i_cach_cnt == 2'h0;
    dma_ld_d = !i_block && dma_turn && i_dma_cnt < DCC_DMA_Q && tot < {1'b0, DCC_QUEUES};
    dma_st_d = !i_block && dma_turn;
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      turn_q <= DCC_SRC_USR;
      o_usr_ld_rdy <= 1'b0;
      o_usr_st_rdy <= 1'b0;
      o_dma_ld_rdy <= 1'b0;
      o_dma_st_rdy <= 1'b0;
    end else begin
      turn_q <= turn_d;
      o_usr_ld_rdy <= usr_ld_d;
      o_usr_st_rdy <= usr_st_d;
      o_dma_ld_rdy <= dma_ld_d;
      o_dma_st_rdy <= dma_st_d;
    end
  end

  AST_ALTERNATE: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (i_dma_active && turn_q == DCC_SRC_USR) |=> turn_q == DCC_SRC_DMA)
    else $error("Issue turn did not alternate while DMA was active.");

  AST_USER_QUOTA: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (i_dma_active && i_usr_cnt >= DCC_USR_Q_DMA_ON) |=> !o_usr_ld_rdy)
    else $error("User load permitted beyond its queue share.");

endmodule : dcc_issue_arb

`default_nettype wire

// File: rtl/dcc_pkg.sv
// Purpose: Shared constants, types and helpers of the data cache coherency controller.
// Assumes: 32-bit byte addresses, word-aligned accesses that stay inside one line.
// Notes:   Sizes travel as word count minus one (0 = word, 3 = quad word).
`default_nettype none

package dcc_pkg;

  // ----------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------
  localparam int unsigned DCC_LINES = 64;
  localparam int unsigned DCC_WORDS = 4;
  localparam int unsigned DCC_ADDR_W = 32;
  localparam int unsigned DCC_WORD_W = 32;
  localparam int unsigned DCC_LINE_W = 128;
  localparam int unsigned DCC_TAG_W = 22;
  localparam int unsigned DCC_IDX_W = 6;
  localparam int unsigned DCC_TAG_LSB = 10;
  localparam int unsigned DCC_IDX_LSB = 4;
  localparam int unsigned DCC_WRD_LSB = 2;

  // ----------------------------------------------------------------------
  // Queue allocation and reset values
  // ----------------------------------------------------------------------
  localparam logic [1:0] DCC_QUEUES = 2'h3;
  localparam logic [1:0] DCC_USR_Q_DMA_ON = 2'h2;
  localparam logic [1:0] DCC_DMA_Q = 2'h1;
  localparam logic DCC_CACHE_ON_RST = 1'b0;

  typedef enum logic {DCC_SRC_USR, DCC_SRC_DMA} dcc_src_t;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [DCC_TAG_W-1:0] dcc_tag_of(input logic [DCC_ADDR_W-1:0] a);
    return a[DCC_ADDR_W-1:DCC_TAG_LSB];
  endfunction : dcc_tag_of

  function automatic logic [DCC_IDX_W-1:0] dcc_idx_of(input logic [DCC_ADDR_W-1:0] a);
    return a[DCC_TAG_LSB-1:DCC_IDX_LSB];
  endfunction : dcc_idx_of

  function automatic logic [1:0] dcc_wrd_of(input logic [DCC_ADDR_W-1:0] a);
    return a[DCC_IDX_LSB-1:DCC_WRD_LSB];
  endfunction : dcc_wrd_of

  function automatic logic [DCC_WORDS-1:0] dcc_word_mask(input logic [1:0] off,
                                                        input logic [1:0] nwm1);
    logic [DCC_WORDS-1:0] m;
    m = '0;
    for (int i = 0; i < int'(DCC_WORDS); i++) begin
      if (i >= int'(off) && i <= int'(off) + int'(nwm1)) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction : dcc_word_mask

  function automatic logic [1:0] dcc_ptr_inc(input logic [1:0] p);
    return (p == DCC_QUEUES - 2'h1) ? 2'h0 : p + 2'h1;
  endfunction : dcc_ptr_inc

endpackage : dcc_pkg

`default_nettype wire

// File: rtl/dcc_tag_array.sv
// Purpose: Direct-mapped line store: tags, line valid, word valids and data.
// Assumes: One write and one invalidate per clock.
// Notes:   A write replaces the tag; word valids become exactly the written words.
`timescale 1ns/1ps
`default_nettype none

module dcc_tag_array
  import dcc_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // Array port
  dcc_arr_if.arr arr
);

  logic [DCC_TAG_W-1:0] tag_q [DCC_LINES];
  logic [DCC_LINE_W-1:0] data_q [DCC_LINES];
  logic [DCC_LINES-1:0] lval_q;
  logic [DCC_LINES-1:0] lval_d;
  logic [DCC_WORDS-1:0] wval_q [DCC_LINES];
  logic [DCC_WORDS-1:0] wval_d [DCC_LINES];

  assign arr.rd_tag = tag_q[arr.rd_idx];
  assign arr.rd_lvalid = lval_q[arr.rd_idx];
  assign arr.rd_wvalid = wval_q[arr.rd_idx];
  assign arr.rd_data = data_q[arr.rd_idx];

  // ----------------------------------------------------------------------
  // Valid bits
  // ----------------------------------------------------------------------
  always_comb begin
    lval_d = lval_q;
    wval_d = wval_q;
    if (arr.wr_en) begin
      lval_d[arr.wr_idx] = 1'b1;
      wval_d[arr.wr_idx] = arr.wr_mask;
    end
    if (arr.inv_en) begin
      lval_d[arr.inv_idx] = 1'b0;
      wval_d[arr.inv_idx] = '0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      lval_q <= '0;
      for (int i = 0; i < int'(DCC_LINES); i++) begin
        wval_q[i] <= '0;
      end
    end else begin
      lval_q <= lval_d;
      wval_q <= wval_d;
    end
  end

  // Tags and data are storage only; their validity is carried by the bits above.
  always_ff @(posedge i_clk_sys) begin
    if (arr.wr_en) begin
      tag_q[arr.wr_idx] <= arr.wr_tag;
      for (int w = 0; w < int'(DCC_WORDS); w++) begin
        if (arr.wr_mask[w]) begin
          data_q[arr.wr_idx][w*DCC_WORD_W +: DCC_WORD_W] <= arr.wr_data[w*DCC_WORD_W +: DCC_WORD_W];
        end
      end
    end
  end

  AST_INV_CLEARS: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    arr.inv_en |=> !lval_q[$past(arr.inv_idx)] && wval_q[$past(arr.inv_idx)] == '0)
    else $error("Invalidated line still holds a valid bit.");

endmodule : dcc_tag_array

`default_nettype wire

// File: sim/dcc_bcu_model.sv
// Purpose: Bus control unit model that answers loads with words equal to their addresses.
// Assumes: Loads are answered in request order, one word per beat.
// Notes: The idle response word is inverted every clock so stale data never matches.
`timescale 1ns/1ps
`default_nettype none
module dcc_bcu_model (
  // Clock, reset and stall
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_stall,
  // Request side
  input wire logic i_req_valid,
  input wire logic i_req_store,
  input wire logic [31:0] i_req_addr,
  input wire logic [1:0] i_req_nwords,
  output logic o_req_ready,
  // Response side
  output logic o_rsp_valid,
  output logic [31:0] o_rsp_word
);
  logic [33:0] q[$];
  logic [1:0] k;
  assign o_req_ready = !i_stall;
  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      q.delete();
      k = 2'h0;
      o_rsp_valid <= 1'b0;
      o_rsp_word <= 32'h0;
    end else begin
      o_rsp_valid <= q.size() > 0;
      if (q.size() == 0) begin
        o_rsp_word <= ~o_rsp_word;
      end else begin
        o_rsp_word <= q[0][33:2] + {28'h0, k, 2'h0};
        k = k + 2'h1;
        if (k == q[0][1:0] + 2'h1) begin
          k = 2'h0;
          void'(q.pop_front());
        end
      end
      if (i_req_valid && o_req_ready && !i_req_store) q.push_back({i_req_addr, i_req_nwords});
    end
  end
endmodule : dcc_bcu_model
`default_nettype wire

// File: sim/testbench.sv
// Purpose: Self-checking bench of the data cache coherency controller.
// Assumes: Inputs change 1 ns after the rising edge; outputs are read at the falling edge.
// Notes: Each scenario issues requests through one shared task and judges the results.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dcc_pkg::*;
  logic i_clk_sys, i_rstn, i_cache_enable, i_dma_active, i_stall;
  logic i_usr_valid, i_usr_store, i_usr_atomic, i_usr_cacheable, o_usr_ld_rdy, o_usr_st_rdy;
  logic i_dma_valid, i_dma_store, o_dma_ld_rdy, o_dma_st_rdy, o_ld_valid, o_ld_src;
  logic [31:0] i_usr_addr, i_dma_addr, o_bcu_req_addr, i_bcu_rsp_word;
  logic [1:0] i_usr_nwords, i_dma_nwords, o_bcu_req_nwords;
  logic [127:0] i_usr_wdata, i_dma_wdata, o_ld_data, o_bcu_req_wdata, d, w;
  logic o_bcu_req_valid, o_bcu_req_store, o_bcu_req_dma, o_bcu_req_cacheable;
  logic i_bcu_req_ready, i_bcu_rsp_valid, miss, rc, rd, s;
  int fails, checks;
  dcc_ctrl uut (.i_clk_sys, .i_rstn, .i_cache_enable, .i_dma_active, .i_usr_valid, .i_usr_store,
    .i_usr_atomic, .i_usr_cacheable, .i_usr_addr, .i_usr_nwords, .i_usr_wdata, .o_usr_ld_rdy,
    .o_usr_st_rdy, .i_dma_valid, .i_dma_store, .i_dma_addr, .i_dma_nwords, .i_dma_wdata,
    .o_dma_ld_rdy, .o_dma_st_rdy, .o_ld_valid, .o_ld_src, .o_ld_data, .o_bcu_req_valid,
    .o_bcu_req_store, .o_bcu_req_dma, .o_bcu_req_cacheable, .o_bcu_req_addr, .o_bcu_req_nwords,
    .o_bcu_req_wdata, .i_bcu_req_ready, .i_bcu_rsp_valid, .i_bcu_rsp_word);
  dcc_bcu_model bcu (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_stall(i_stall),
    .i_req_valid(o_bcu_req_valid), .i_req_store(o_bcu_req_store),
    .i_req_addr(o_bcu_req_addr), .i_req_nwords(o_bcu_req_nwords),
    .o_req_ready(i_bcu_req_ready), .o_rsp_valid(i_bcu_rsp_valid), .o_rsp_word(i_bcu_rsp_word));
  task automatic chk(input logic [127:0] g, input logic [127:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic op(input logic dm, st, at, ca, input logic [31:0] a, input logic [1:0] nw);
    int n;
    {miss, rc, rd, s, w, d} = '0;
    if (dm) {i_dma_valid, i_dma_store, i_dma_addr, i_dma_nwords} = {1'b1, st, a, nw};
    else {i_usr_valid, i_usr_store, i_usr_atomic, i_usr_cacheable, i_usr_addr, i_usr_nwords} =
      {1'b1, st, at, ca, a, nw};
    i_usr_wdata = {4{a}};
    i_dma_wdata = {4{a}};
    n = 0;
    do @(negedge i_clk_sys);
    while ((dm ? (st ? o_dma_st_rdy : o_dma_ld_rdy) : (st ? o_usr_st_rdy : o_usr_ld_rdy)) !== 1'b1
      && ++n < 50);
    if (n >= 50) fails++;
    @(posedge i_clk_sys);
    #1 i_usr_valid = 1'b0;
    i_dma_valid = 1'b0;
    for (n = 0; n < 20 && d === '0; n++) begin
      @(negedge i_clk_sys);
      if (o_bcu_req_valid === 1'b1 && !miss)
        {miss, rc, rd, w} = {1'b1, o_bcu_req_cacheable, o_bcu_req_dma, o_bcu_req_wdata};
      if (o_ld_valid === 1'b1) {s, d} = {o_ld_src, o_ld_data};
    end
    @(posedge i_clk_sys) #1;
  endtask : op
  task automatic t_fill();
    op(0, 0, 0, 1, 32'h1000, 2'h0);
    chk(miss, 1'b1);
    chk(d[31:0], 32'h1000);
    op(0, 0, 0, 1, 32'h1000, 2'h0);
    chk(miss, 1'b0);
    chk(d[31:0], 32'h1000);
    chk(s, 1'b0);
  endtask : t_fill
  task automatic t_quad();
    op(0, 0, 0, 1, 32'h2000, 2'h3);
    chk(d, {32'h200c, 32'h2008, 32'h2004, 32'h2000});
    op(0, 0, 0, 1, 32'h2000, 2'h3);
    chk(miss, 1'b0);
    chk(d, {32'h200c, 32'h2008, 32'h2004, 32'h2000});
  endtask : t_quad
  task automatic t_snoop();
    op(0, 1, 0, 1, 32'h3000, 2'h0);
    chk(rc, 1'b1);
    chk(w, {4{32'h3000}});
    op(0, 0, 0, 1, 32'h3000, 2'h0);
    chk(miss, 1'b0);
    chk(d[31:0], 32'h3000);
    op(0, 1, 0, 0, 32'h3000, 2'h0);
    chk(rc, 1'b0);
    op(0, 0, 0, 1, 32'h3000, 2'h0);
    chk(miss, 1'b1);
    i_cache_enable = 1'b0;
    @(posedge i_clk_sys) #1;
    op(0, 1, 0, 1, 32'h3000, 2'h0);
    chk(rc, 1'b0);
    i_cache_enable = 1'b1;
    @(posedge i_clk_sys) #1;
    op(0, 0, 0, 1, 32'h3000, 2'h0);
    chk(miss, 1'b1);
  endtask : t_snoop
  task automatic t_dma();
    i_dma_active = 1'b1;
    op(1, 1, 0, 1, 32'h4000, 2'h1);
    chk(rd, 1'b1);
    chk(rc, 1'b0);
    chk(w, {4{32'h4000}});
    op(1, 0, 0, 0, 32'h5000, 2'h0);
    chk(d[31:0], 32'h5000);
    chk(s, 1'b1);
    op(0, 0, 1, 1, 32'h3000, 2'h0);
    chk(miss, 1'b1);
    chk(rc, 1'b0);
    i_dma_active = 1'b0;
  endtask : t_dma
  task automatic print_verdict();
    if (fails == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    i_clk_sys = 1'b0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end
  initial begin
    #200000 fails++;
    print_verdict();
  end
  initial begin
    {i_rstn, i_dma_active, i_usr_valid, i_dma_valid, i_usr_store, i_dma_store} = '0;
    {i_usr_atomic, i_usr_cacheable, i_usr_addr, i_dma_addr, i_usr_nwords, i_dma_nwords} = '0;
    {i_usr_wdata, i_dma_wdata, fails, checks} = '0;
    i_cache_enable = 1'b1;
    i_stall = 1'b1;
    repeat (6) @(posedge i_clk_sys);
    #1 i_rstn = 1'b1;
    fork
      #600 i_stall = 1'b0;
    join_none
    t_fill();
    t_quad();
    t_snoop();
    t_dma();
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
